// ==== design/flash_seq_pkg.sv ====
package flash_seq_pkg;

    // Array geometry: three bytes per instruction word
    localparam int ROW_WORDS = 64;
    localparam int ROW_BYTES = 192;
    localparam int BLOCK_ROWS = 8;
    localparam int BLOCK_WORDS = 512;
    localparam int BLOCK_BYTES = 1536;
    // Modelled array: two erase blocks, word index width
    localparam int ARRAY_AW = 10;
    localparam int FLASH_WORDS = 1024;

    // Register byte offsets on the bus
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_KEY = 8'h04;
    localparam logic [7:0] OFS_PAGE = 8'h08;
    localparam logic [7:0] OFS_EADDR = 8'h0c;
    localparam logic [7:0] OFS_DLOW = 8'h10;
    localparam logic [7:0] OFS_DHIGH = 8'h14;
    localparam logic [7:0] OFS_TCFG = 8'h18;
    localparam logic [7:0] OFS_STAT = 8'h1c;

    // Control, status and table-config register bit positions
    localparam int CTRL_GO_BIT = 15;
    localparam int CTRL_PERMIT_BIT = 14;
    localparam int CTRL_FAULT_BIT = 13;
    localparam int CTRL_ERASE_BIT = 6;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_CFGHIT_BIT = 1;
    localparam int TCFG_BYTE_BIT = 0;

    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;

    localparam logic [3:0] OPSEL_ROW_PROG = 4'h1;
    localparam logic [3:0] OPSEL_PAGE_ERASE = 4'h2;
    localparam logic [3:0] OPSEL_WORD_PROG = 4'h3;

    localparam logic [23:0] ERASED_WORD = 24'hffffff;
    localparam logic [7:0] PAGE_RST = 8'h00;
    localparam logic [15:0] EADDR_RST = 16'h0000;

    // Self-timed operation lengths
    localparam int CLK_PERIOD_NS = 10;
    localparam int ROW_PROG_TIME_NS = 2000;
    localparam int WORD_PROG_TIME_NS = 1000;
    localparam int PAGE_ERASE_TIME_NS = 20000;
    localparam int TIMER_W = 12;
    localparam logic [TIMER_W-1:0] ROW_PROG_CYC =
        TIMER_W'((ROW_PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TIMER_W-1:0] WORD_PROG_CYC =
        TIMER_W'((WORD_PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TIMER_W-1:0] PAGE_ERASE_CYC =
        TIMER_W'((PAGE_ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Extra data-phase cycle so a latch store spans two cycles
    localparam logic [1:0] TBL_WAIT_CYC = 2'h1;
    localparam logic [8:0] LAST_BLOCK_IDX = 9'(BLOCK_WORDS - 1);
    localparam logic [8:0] LAST_ROW_IDX = 9'(ROW_WORDS - 1);

    typedef enum logic [1:0] {
        KEY_IDLE = 2'b00,
        KEY_HALF = 2'b01,
        KEY_ARMED = 2'b10
    } keyState_t;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_TIMING = 2'b01,
        SEQ_COMMIT = 2'b10,
        SEQ_DONE = 2'b11
    } seqState_t;

    typedef struct packed {
        logic go;
        logic permit;
        logic fault;
        logic erase;
        logic [3:0] opsel;
    } ctrl_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic hit;
        logic [7:0] addr;
    } busPhase_t;

    localparam ctrl_t CTRL_RST = '{go: 1'b0, permit: 1'b0, fault: 1'b0, erase: 1'b0,
        opsel: 4'h0};
    localparam busPhase_t PHASE_RST = '{valid: 1'b0, write: 1'b0, hit: 1'b0, addr: 8'h00};

endpackage

// ==== design/flash_self_program_sequencer.sv ====
`timescale 1ns/1ps

// Function
// - Array is rows of 64 words; erase blocks are eight rows, 512 words.
// - Erase blocks align to 1536 bytes, rows to 192 bytes, from address zero.
// - Besides row program and block erase, a single word can be programmed.
// - Table stores land in holding latches, never directly in the array.
// - Any number of latch loads allowed; a full row needs 64 stores.
// - Latches load in any order; a later store replaces the earlier one.
// - A latch store takes two cycles; each row needs its own program cycle.
// - Target address is page register concatenated with 16-bit effective address.
// - Low table accesses reach bits 15..0, in word or byte mode.
// - High table accesses reach bits 23..16, in word or byte mode.
// - Key register is write-only; 55h then AAh must precede any operation.
// - Go bit 15 starts the operation; hardware clears it when finished.
// - Core is held stalled while an operation runs, released at completion.
// - Control register selects erase, operation type, and start.
// - Last two words hold configuration; erasing the last page clears them.
// - Permit bit clear inhibits every program or erase start.
// - 0010+erase is page erase, 0001 row program, 0011 word program, else none.
// - Fault flag sets on a bad start attempt; clears on normal completion.
module flash_self_program_sequencer
    import flash_seq_pkg::*;
(
    input wire logic mclk, // System clock, 100 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Transfer size, word only
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    output logic hreadyout, // Slave ready, low stalls the core
    output logic [31:0] hrdata, // Read data
    output logic hresp, // Always OKAY
    output logic cpuStall // High while an operation runs
);

    busPhase_t ph_ff;
    busPhase_t nxt_ph;
    ctrl_t ctrl_ff;
    ctrl_t nxt_ctrl;
    keyState_t key_ff;
    keyState_t nxt_key;
    seqState_t seq_ff;
    seqState_t nxt_seq;
    logic readyOut_ff;
    logic [31:0] rdata_ff;
    logic hresp_ff;
    logic stall_ff;
    logic [1:0] waitCnt_ff;
    logic [1:0] nxt_waitCnt;
    logic [7:0] page_ff;
    logic [15:0] eaddr_ff;
    logic byteMode_ff;
    logic cfgHit_ff;
    logic nxt_cfgHit;
    logic [TIMER_W-1:0] timer_ff;
    logic [TIMER_W-1:0] nxt_timer;
    logic [8:0] idx_ff;
    logic [8:0] nxt_idx;
    logic [ARRAY_AW-1:0] tgt_ff;

    logic [23:0] flashMem [0:FLASH_WORDS-1];
    logic [23:0] latchMem [0:ROW_WORDS-1];

    // Bus phase tracking
    wire addrTaken = hsel && htrans[1] && hready;
    wire addrHit = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00) && (haddr[7:5] == 3'b000);
    wire addrIsData = (haddr[7:0] == OFS_DLOW) || (haddr[7:0] == OFS_DHIGH);
    wire busy = (seq_ff != SEQ_IDLE);
    wire phaseDone = ph_ff.valid && !readyOut_ff && !busy && (waitCnt_ff == 2'h0);
    wire wrDone = phaseDone && ph_ff.write && ph_ff.hit;
    wire wrCtrl = wrDone && (ph_ff.addr == OFS_CTRL);
    wire wrKey = wrDone && (ph_ff.addr == OFS_KEY);
    wire wrPage = wrDone && (ph_ff.addr == OFS_PAGE);
    wire wrEaddr = wrDone && (ph_ff.addr == OFS_EADDR);
    wire wrLow = wrDone && (ph_ff.addr == OFS_DLOW);
    wire wrHigh = wrDone && (ph_ff.addr == OFS_DHIGH);
    wire wrTcfg = wrDone && (ph_ff.addr == OFS_TCFG);
    wire wrStat = wrDone && (ph_ff.addr == OFS_STAT);

    wire [23:0] fullAddr = {page_ff, eaddr_ff};
    wire [ARRAY_AW-1:0] wordIdx = fullAddr[ARRAY_AW:1];
    wire [5:0] latchIdx = fullAddr[6:1];
    wire byteSel = fullAddr[0];
    // Table stores into configuration space are not allowed
    wire cfgSpace = page_ff[7];

    wire latchWr = (wrLow || wrHigh) && !cfgSpace;
    wire [23:0] latchOld = latchMem[latchIdx];
    logic [23:0] latchNew;
    wire [23:0] lowWord = {latchOld[23:16], hwdata[15:0]};
    wire [23:0] lowByte = byteSel ? {latchOld[23:16], hwdata[7:0], latchOld[7:0]}
                                  : {latchOld[23:8], hwdata[7:0]};
    // high byte store; phantom byte ignored
    wire [23:0] highVal = (byteMode_ff && byteSel) ? latchOld : {hwdata[7:0], latchOld[15:0]};
    assign latchNew = wrLow ? (byteMode_ff ? lowByte : lowWord) : highVal;

    // Table fetches read the array directly
    wire [23:0] fetchWord = flashMem[wordIdx];
    wire [31:0] fetchLow = byteMode_ff ? {24'h000000, byteSel ? fetchWord[15:8] : fetchWord[7:0]}
                                       : {16'h0000, fetchWord[15:0]};
    // high fetch, phantom byte reads zero
    wire [31:0] fetchHigh = (byteMode_ff && byteSel) ? 32'h00000000
                                                     : {24'h000000, fetchWord[23:16]};

    wire [31:0] ctrlRead = {16'h0000, ctrl_ff.go, ctrl_ff.permit, ctrl_ff.fault, 6'h00,
        ctrl_ff.erase, 2'b00, ctrl_ff.opsel};
    logic [31:0] rdMux;
    always_comb begin
        case (ph_ff.addr)
            OFS_CTRL: rdMux = ctrlRead;
            OFS_PAGE: rdMux = {24'h000000, page_ff};
            OFS_EADDR: rdMux = {16'h0000, eaddr_ff};
            OFS_DLOW: rdMux = fetchLow;
            OFS_DHIGH: rdMux = fetchHigh;
            OFS_TCFG: rdMux = {31'h00000000, byteMode_ff};
            OFS_STAT: rdMux = {30'h00000000, cfgHit_ff, busy};
            default: rdMux = 32'h00000000;
        endcase
    end
    wire [31:0] rdNext = (ph_ff.hit && !ph_ff.write) ? rdMux : 32'h00000000;

    // operation decode from the value being written
    wire [3:0] wOp = hwdata[3:0];
    wire wErase = hwdata[CTRL_ERASE_BIT];
    wire opValid = ((wOp == OPSEL_PAGE_ERASE) && wErase) ||
                   ((wOp == OPSEL_ROW_PROG) && !wErase) ||
                   ((wOp == OPSEL_WORD_PROG) && !wErase);
    wire goReq = wrCtrl && hwdata[CTRL_GO_BIT] && !ctrl_ff.go;
    wire goOk = goReq && (key_ff == KEY_ARMED) && hwdata[CTRL_PERMIT_BIT] && opValid;
    wire seqDone = (seq_ff == SEQ_DONE);

    // key sequence; any other write to a mapped register breaks it
    always_comb begin
        nxt_key = key_ff;
        if (wrKey) begin
            if (hwdata[7:0] == KEY_FIRST) begin
                nxt_key = KEY_HALF;
            end else if ((hwdata[7:0] == KEY_SECOND) && (key_ff == KEY_HALF)) begin
                nxt_key = KEY_ARMED;
            end else begin
                nxt_key = KEY_IDLE;
            end
        end else if (wrDone) begin
            nxt_key = KEY_IDLE;
        end
    end

    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (wrCtrl) begin
            nxt_ctrl.permit = hwdata[CTRL_PERMIT_BIT];
            nxt_ctrl.fault = hwdata[CTRL_FAULT_BIT];
            nxt_ctrl.erase = wErase;
            nxt_ctrl.opsel = wOp;
        end
        if (goOk) begin
            nxt_ctrl.go = 1'b1;
        end
        // failed start sets fault; set beats the software write
        if (goReq && !goOk) begin
            nxt_ctrl.fault = 1'b1;
        end
        if (seqDone) begin
            nxt_ctrl.go = 1'b0;
            nxt_ctrl.fault = 1'b0;
        end
    end

    // last-block erase wipes configuration words, flagged in status
    wire lastBlock = &tgt_ff[ARRAY_AW-1:9];
    wire cfgHitSet = seqDone && ctrl_ff.erase && lastBlock;
    assign nxt_cfgHit = cfgHitSet || (cfgHit_ff && !(wrStat && hwdata[STAT_CFGHIT_BIT]));

    wire isRow = (ctrl_ff.opsel == OPSEL_ROW_PROG);
    wire [8:0] lastIdx = ctrl_ff.erase ? LAST_BLOCK_IDX : (isRow ? LAST_ROW_IDX : 9'h000);
    // aligned bases by dropping low index bits
    // word program uses the target alone
    wire [ARRAY_AW-1:0] commitAddr = ctrl_ff.erase ? {tgt_ff[ARRAY_AW-1:9], idx_ff}
                                   : (isRow ? {tgt_ff[ARRAY_AW-1:6], idx_ff[5:0]} : tgt_ff);
    wire [5:0] commitLatch = isRow ? idx_ff[5:0] : tgt_ff[5:0];
    // Programming can only clear bits, so a second program without erase merges
    wire [23:0] commitData = ctrl_ff.erase ? ERASED_WORD
                                           : (flashMem[commitAddr] & latchMem[commitLatch]);
    wire [TIMER_W-1:0] opCycles = ctrl_ff.erase ? PAGE_ERASE_CYC
                                : (isRow ? ROW_PROG_CYC : WORD_PROG_CYC);

    always_comb begin
        nxt_seq = seq_ff;
        nxt_timer = timer_ff;
        nxt_idx = idx_ff;
        case (seq_ff)
            SEQ_IDLE: begin
                if (goOk) begin
                    nxt_seq = SEQ_TIMING;
                end
            end
            SEQ_TIMING: begin
                if (timer_ff >= opCycles - TIMER_W'(1)) begin
                    nxt_seq = SEQ_COMMIT;
                    nxt_idx = 9'h000;
                end else begin
                    nxt_timer = timer_ff + TIMER_W'(1);
                end
            end
            SEQ_COMMIT: begin
                if (idx_ff == lastIdx) begin
                    nxt_seq = SEQ_DONE;
                end else begin
                    nxt_idx = idx_ff + 9'h001;
                end
            end
            SEQ_DONE: begin
                nxt_seq = SEQ_IDLE;
            end
            default: begin
                nxt_seq = SEQ_IDLE;
            end
        endcase
        if (seq_ff == SEQ_IDLE) begin
            nxt_timer = '0;
        end
    end

    // Address phase capture; latch stores get one extra wait cycle
    always_comb begin
        nxt_ph = ph_ff;
        nxt_waitCnt = (waitCnt_ff != 2'h0) ? waitCnt_ff - 2'h1 : 2'h0;
        if (phaseDone) begin
            nxt_ph.valid = 1'b0;
        end
        if (addrTaken) begin
            nxt_ph.valid = 1'b1;
            nxt_ph.write = hwrite;
            nxt_ph.hit = addrHit;
            nxt_ph.addr = haddr[7:0];
            nxt_waitCnt = (hwrite && addrHit && addrIsData) ? TBL_WAIT_CYC : 2'h0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ph_ff <= PHASE_RST;
            readyOut_ff <= 1'b1;
            rdata_ff <= 32'h00000000;
            hresp_ff <= 1'b0;
            waitCnt_ff <= 2'h0;
        end else begin
            ph_ff <= nxt_ph;
            readyOut_ff <= addrTaken ? 1'b0 : (phaseDone ? 1'b1 : readyOut_ff);
            rdata_ff <= phaseDone ? rdNext : rdata_ff;
            hresp_ff <= 1'b0;
            waitCnt_ff <= nxt_waitCnt;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_ff <= CTRL_RST;
            key_ff <= KEY_IDLE;
            page_ff <= PAGE_RST;
            eaddr_ff <= EADDR_RST;
            byteMode_ff <= 1'b0;
            cfgHit_ff <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            key_ff <= nxt_key;
            page_ff <= wrPage ? hwdata[7:0] : page_ff;
            eaddr_ff <= wrEaddr ? hwdata[15:0] : eaddr_ff;
            byteMode_ff <= wrTcfg ? hwdata[TCFG_BYTE_BIT] : byteMode_ff;
            cfgHit_ff <= nxt_cfgHit;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            seq_ff <= SEQ_IDLE;
            timer_ff <= '0;
            idx_ff <= 9'h000;
            tgt_ff <= '0;
            stall_ff <= 1'b0;
        end else begin
            seq_ff <= nxt_seq;
            timer_ff <= nxt_timer;
            idx_ff <= nxt_idx;
            tgt_ff <= goOk ? wordIdx : tgt_ff;
            stall_ff <= (nxt_seq != SEQ_IDLE);
        end
    end

    // Latches have no reset: contents are unknown until loaded
    // any number of loads
    always_ff @(posedge mclk) begin
        if (latchWr) begin
            latchMem[latchIdx] <= latchNew;
        end
    end

    // array changes only in the commit pass
    always_ff @(posedge mclk) begin
        if (seq_ff == SEQ_COMMIT) begin
            flashMem[commitAddr] <= commitData;
        end
    end

    assign hreadyout = readyOut_ff;
    assign hrdata = rdata_ff;
    assign hresp = hresp_ff;
    assign cpuStall = stall_ff;

endmodule // flash_self_program_sequencer

// ==== dv/flash_seq_chk.sv ====
`timescale 1ns/1ps
module flash_seq_chk
    import flash_seq_pkg::*;
(
    input wire logic mclk, // Clock
    input wire logic rst, // Reset
    input wire logic hsel, // Select
    input wire logic [31:0] haddr, // Address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write
    input wire logic [2:0] hsize, // Size
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    input wire logic hreadyout, // Slave ready
    input wire logic [31:0] hrdata, // Read data
    input wire logic hresp, // Response
    input wire logic cpuStall // Core stall
);
    // Shortest operation is a word program; longest is an erase plus its commit pass
    localparam int STALL_MIN = WORD_PROG_CYC;
    localparam int STALL_MAX = PAGE_ERASE_CYC + BLOCK_WORDS + 2;
    logic phV_ff;
    logic phW_ff;
    logic [7:0] phA_ff;
    logic was55_ff;
    logic armed_ff;
    logic [11:0] stallCnt_ff;
    wire accept = hsel && htrans[1] && hready;
    wire mapped = haddr[31:8] == 24'h0 && haddr[7:0] <= OFS_STAT && haddr[1:0] == 2'h0;
    wire latchWr = hwrite && (haddr[7:0] == OFS_DLOW || haddr[7:0] == OFS_DHIGH);
    wire wDone = phV_ff && phW_ff && hreadyout;
    wire eraseOp = hwdata[CTRL_ERASE_BIT] && hwdata[3:0] == OPSEL_PAGE_ERASE;
    wire progOp = !hwdata[CTRL_ERASE_BIT]
        && (hwdata[3:0] == OPSEL_ROW_PROG || hwdata[3:0] == OPSEL_WORD_PROG);
    wire goWr = wDone && phA_ff == OFS_CTRL && hwdata[CTRL_GO_BIT];
    wire goOk = goWr && armed_ff && hwdata[CTRL_PERMIT_BIT] && (eraseOp || progOp);
    always_ff @(posedge mclk) begin
        if (rst) begin
            phV_ff <= 1'b0;
        end else if (hreadyout) begin
            phV_ff <= accept;
        end
    end
    always_ff @(posedge mclk) begin
        if (hreadyout && accept) begin
            phW_ff <= hwrite;
            phA_ff <= haddr[7:0];
        end
    end
    // Any completed write other than the second key drops the arming
    always_ff @(posedge mclk) begin
        if (rst) begin
            was55_ff <= 1'b0;
            armed_ff <= 1'b0;
        end else if (wDone) begin
            was55_ff <= phA_ff == OFS_KEY && hwdata[7:0] == KEY_FIRST;
            armed_ff <= was55_ff && phA_ff == OFS_KEY && hwdata[7:0] == KEY_SECOND;
        end
    end
    always_ff @(posedge mclk) begin
        stallCnt_ff <= (rst || !cpuStall) ? 12'h0 : stallCnt_ff + 12'h1;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_one_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    sequence s_two_wait;
        !hreadyout [*2] ##1 hreadyout;
    endsequence
    a_accept_low: assert property (accept |=> !hreadyout)
        else $error("accepted transfer did not wait");
    a_wait_bound: assert property (!hreadyout && !cpuStall |-> ##[1:3] hreadyout)
        else $error("data phase wait too long");
    a_stall_hold: assert property (cpuStall && !hreadyout |=> !hreadyout || !cpuStall)
        else $error("core released during operation");
    a_reg_latency: assert property (accept && mapped && !latchWr && !cpuStall |=> s_one_wait)
        else $error("register access latency wrong");
    a_latch_cycles: assert property (accept && mapped && latchWr && !cpuStall |=> s_two_wait)
        else $error("latch store latency wrong");
    a_stall_min: assert property ($fell(cpuStall) |-> stallCnt_ff >= STALL_MIN)
        else $error("operation ended too early");
    a_stall_max: assert property (stallCnt_ff <= STALL_MAX)
        else $error("operation never ended");
    a_go_start: assert property (goOk |=> cpuStall)
        else $error("unlocked start not taken");
    // The start is decided one edge before the write is seen done, so look at once
    a_go_refused: assert property (goWr && !goOk |-> !cpuStall [*3])
        else $error("refused start stalled the core");
    a_resp_okay: assert property (!hresp)
        else $error("slave response not OKAY");
    a_key_reads_zero: assert property (phV_ff && !phW_ff && hreadyout && phA_ff == OFS_KEY
        |-> hrdata == 32'h0)
        else $error("key register read not zero");
endmodule // flash_seq_chk

bind flash_self_program_sequencer flash_seq_chk i_chk(.mclk(mclk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .cpuStall(cpuStall));

// ==== dv/flash_core_model.sv ====
`timescale 1ns/1ps
module flash_core_model
    import flash_seq_pkg::*;
(
    input wire logic mclk, // Clock
    input wire logic hready, // Bus ready
    input wire logic [31:0] hrdata, // Read data
    output logic hsel, // Select
    output logic [31:0] haddr, // Address
    output logic [1:0] htrans, // Transfer type
    output logic hwrite, // Write
    output logic [2:0] hsize, // Word size
    output logic [31:0] hwdata // Write data
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r);
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge mclk);
        while (!hready) @(posedge mclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge mclk);
        while (!hready) @(posedge mclk);
        r = hrdata;
        // Released data lines flip so a stale value never passes for a live one
        hsel <= 1'b0;
        hwdata <= ~d;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        xfer(1'b0, a, 32'h0, r);
    endtask
    // two key writes back to back
    task automatic unlock;
        wr(OFS_KEY, {24'h0, KEY_FIRST});
        wr(OFS_KEY, {24'h0, KEY_SECOND});
    endtask
    // one latch store: pointer, low part, high part
    task automatic store(input logic [15:0] effAddr, input logic [23:0] w);
        wr(OFS_EADDR, {16'h0, effAddr});
        wr(OFS_DLOW, {16'h0, w[15:0]});
        wr(OFS_DHIGH, {24'h0, w[23:16]});
    endtask
    // all 64 latches of one row preset to ones; no program is started
    task automatic fillRow(input logic [15:0] base);
        for (int i = 0; i < ROW_WORDS; i++) begin
            store(base + 16'(2 * i), ERASED_WORD);
        end
    endtask
endmodule // flash_core_model

// ==== dv/flash_self_program_sequencer_bench.sv ====
`timescale 1ns/1ps
module flash_self_program_sequencer_bench
    import flash_seq_pkg::*;
;
    logic mclk;
    logic rst;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic cpuStall;
    logic [31:0] r;
    logic [23:0] got;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    flash_self_program_sequencer i_dut(.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .cpuStall(cpuStall));
    flash_core_model i_core(.mclk(mclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    initial mclk = 1'b0;
    always #5 mclk = ~mclk;
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rdWord(input logic [15:0] effAddr, output logic [23:0] w);
        logic [31:0] lo;
        logic [31:0] hi;
        i_core.wr(OFS_EADDR, {16'h0, effAddr});
        i_core.rd(OFS_DLOW, lo);
        i_core.rd(OFS_DHIGH, hi);
        w = {hi[7:0], lo[15:0]};
    endtask
    task automatic test_regs;
        i_core.rd(OFS_CTRL, r);
        chk("ctrl reset", 32'h0, r);
        i_core.wr(OFS_KEY, 32'h55);
        i_core.rd(OFS_KEY, r);
        chk("key read", 32'h0, r);
        i_core.wr(OFS_PAGE, 32'h7f);
        i_core.rd(OFS_PAGE, r);
        chk("page", 32'h7f, r);
        i_core.rd(8'h40, r);
        chk("unmapped", 32'h0, r);
        $display("test regs done");
    endtask
    task automatic test_refused;
        int mode [5] = '{0, 1, 1, 1, 2};
        logic [31:0] ctl [5] = '{32'hc001, 32'h8001, 32'hc041, 32'hc04f, 32'hc001};
        for (int i = 0; i < 5; i++) begin
            if (mode[i] > 0) i_core.unlock();
            if (mode[i] == 2) i_core.wr(OFS_PAGE, 32'h0);
            i_core.wr(OFS_CTRL, ctl[i]);
            chk("stall", 32'h0, {31'h0, cpuStall});
            i_core.rd(OFS_CTRL, r);
            chk("fault", (ctl[i] & 32'h7fff) | 32'h2000, r);
        end
        $display("test refused done");
    endtask
    task automatic test_erase_row;
        logic [15:0] eas [5] = '{16'h0086, 16'h0094, 16'h0080, 16'h007e, 16'h0100};
        logic [23:0] exps [5] = '{24'habcdef, 24'h0f1e2d, 24'hffffff, 24'hffffff, 24'hffffff};
        i_core.wr(OFS_PAGE, 32'h0);
        i_core.wr(OFS_EADDR, 32'h0);
        i_core.unlock();
        i_core.wr(OFS_CTRL, 32'hc042);
        chk("stall", 32'h1, {31'h0, cpuStall});
        i_core.rd(OFS_CTRL, r);
        chk("erase done", 32'h4042, r);
        rdWord(16'h03fe, got);
        chk("block end", 32'hffffff, {8'h0, got});
        i_core.fillRow(16'h0080);
        i_core.store(16'h0086, 24'h123456);
        i_core.store(16'h0086, 24'habcdef);
        i_core.store(16'h0094, 24'h0f1e2d);
        rdWord(16'h0086, got);
        chk("before program", 32'hffffff, {8'h0, got});
        i_core.unlock();
        i_core.wr(OFS_CTRL, 32'hc001);
        i_core.rd(OFS_CTRL, r);
        chk("row done", 32'h4001, r);
        for (int i = 0; i < 5; i++) begin
            rdWord(eas[i], got);
            chk("row word", {8'h0, exps[i]}, {8'h0, got});
        end
        i_core.wr(OFS_TCFG, 32'h1);
        i_core.wr(OFS_EADDR, 32'h87);
        i_core.rd(OFS_DLOW, r);
        chk("byte low", 32'hcd, r);
        i_core.wr(OFS_EADDR, 32'h86);
        i_core.rd(OFS_DHIGH, r);
        chk("byte high", 32'hab, r);
        i_core.wr(OFS_TCFG, 32'h0);
        $display("test erase row done");
    endtask
    task automatic test_word;
        i_core.store(16'h0102, 24'h00ff00);
        i_core.unlock();
        i_core.wr(OFS_CTRL, 32'hc003);
        i_core.rd(OFS_CTRL, r);
        chk("word done", 32'h4003, r);
        rdWord(16'h0102, got);
        chk("word", 32'h00ff00, {8'h0, got});
        rdWord(16'h0104, got);
        chk("next word", 32'hffffff, {8'h0, got});
        i_core.wr(OFS_EADDR, 32'h400);
        i_core.unlock();
        i_core.wr(OFS_CTRL, 32'hc042);
        i_core.rd(OFS_STAT, r);
        chk("config hit", 32'h2, r);
        $display("test word done");
    endtask
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    initial begin
        rst = 1'b1;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        test_regs();
        test_refused();
        test_erase_row();
        test_word();
        tally_and_finish();
    end
endmodule // flash_self_program_sequencer_bench
